// ==== hdl/sdlc_loop_consts.svh ====
`ifndef SDLC_LOOP_CONSTS_SVH
`define SDLC_LOOP_CONSTS_SVH
`define FLAG_BYTE 8'h7E
`define BCAST_ADDR 8'hFF
`define CRC_INIT 16'hFFFF
`define CRC_POLY 16'h1021
`define CRC_GOOD 16'h0000
`define ONES_STUFF 4'h5
`define ONES_FLAG 4'h6
`define ONES_IDLE 4'hF
`define LAST_BIT 4'h7
`define LAST_FCS_BIT 4'hF
`define FIFO_DEPTH 4'hA
`define FIFO_LAST 4'h9
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_TXDATA 8'h08
`define REG_RXDATA 8'h0C
`define REG_FSTAT 8'h10
`define CTRL_GO 0
`define CTRL_BLOCK 1
`define CTRL_ABORT 2
`define CTRL_ERST 3
`define CTRL_ADDR 15:8
`define STAT_EXT 2
`define STAT_OVF 8
`endif

// ==== hdl/sdlc_loop_pkg.sv ====
package sdlc_loop_pkg;
   typedef enum logic [2:0] {
      LP_GATE = 3'h1,
      LP_RELAY = 3'h2,
      LP_SEND = 3'h4
   } loop_t;
   typedef enum logic [1:0] {
      RX_HUNT = 2'h1,
      RX_SYNC = 2'h2
   } rx_state_t;
   typedef enum logic [4:0] {
      TX_FLAG = 5'h01,
      TX_DATA = 5'h02,
      TX_FCS = 5'h04,
      TX_CLOSE = 5'h08,
      TX_MARK = 5'h10
   } tx_state_t;
endpackage

// ==== hdl/sdlc_ring_if.sv ====
`timescale 1ns/1ps
interface sdlc_ring_if;
   logic down; // line from the master towards the secondary
   logic up; // line from the secondary back to the master
   modport master (output down, input up);
   modport secondary (input down, output up);
endinterface

// ==== hdl/sdlc_crc16.sv ====
`timescale 1ns/1ps
`include "sdlc_loop_consts.svh"
module sdlc_crc16 (
   input wire logic [15:0] crc_in, // running remainder
   input wire logic [7:0] data, // octet, bit 0 first on the line
   output logic [15:0] crc_out // remainder after the octet
);
   always_comb begin
      crc_out = crc_in;
      for (int i = 0; i < 8; i++) begin
         if (crc_out[15] ^ data[i]) begin
            crc_out = {crc_out[14:0], 1'b0} ^ `CRC_POLY;
         end else begin
            crc_out = {crc_out[14:0], 1'b0};
         end
      end
   end
endmodule

// ==== hdl/sdlc_secondary.sv ====
// The AHB-Lite slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sdlc_loop_consts.svh"
module sdlc_secondary
   import sdlc_loop_pkg::*;
(
   input wire logic mclk, // bit-rate clock
   input wire logic rst, // synchronous reset
   input wire logic hsel, // ahb slave select
   input wire logic [31:0] haddr, // ahb address
   input wire logic [1:0] htrans, // ahb transfer type
   input wire logic hwrite, // ahb write
   input wire logic [2:0] hsize, // ahb size, word only
   input wire logic [31:0] hwdata, // ahb write data
   input wire logic hready, // ahb bus ready
   output logic hreadyout, // ahb ready, low = wait
   output logic hresp, // ahb response, always okay
   output logic [31:0] hrdata, // ahb read data
   output logic rx_req, // receive byte waiting for dma
   sdlc_ring_if.secondary ring // ring line
);
   // ----------------------------------------
   // register bus
   // ----------------------------------------
   logic d_act, d_wr, stall, done, wr_done, rd_done;
   logic [7:0] d_addr;
   logic [31:0] rd_mux;
   logic go_active_on_poll, block_mode, abort_cmd, erst_cmd;
   logic [7:0] station;
   logic tx_full, rx_full, locked, ext_event, brk, on_loop, sending;
   logic fifo_ovf, fifo_pop;
   logic [3:0] fw, fr, fcnt;
   logic [16:0] fst_mem [0:9];
   logic [7:0] txbuf, rxbuf;
   rx_state_t rxs;

   assign stall = block_mode && d_act && ((d_wr && d_addr == `REG_TXDATA
      && tx_full) || (!d_wr && d_addr == `REG_RXDATA && !rx_full
      && !locked));
   assign done = d_act && !stall;
   assign wr_done = done && d_wr;
   assign rd_done = done && !d_wr;
   assign abort_cmd = wr_done && d_addr == `REG_CTRL && hwdata[`CTRL_ABORT];
   assign erst_cmd = wr_done && d_addr == `REG_CTRL && hwdata[`CTRL_ERST];

   always_comb begin
      rd_mux = 32'h0;
      case (d_addr)
         `REG_CTRL: rd_mux = {16'h0, station, 6'h0, block_mode,
            go_active_on_poll};
         `REG_STATUS: rd_mux = {19'h0, fcnt, fifo_ovf, locked, !tx_full,
            rx_full, rxs == RX_HUNT, brk, ext_event, sending, on_loop};
         `REG_RXDATA: rd_mux = {24'h0, rxbuf};
         `REG_FSTAT: rd_mux = {fcnt != 4'h0, 14'h0, fst_mem[fr]};
         default: rd_mux = 32'h0;
      endcase
   end

   // every transfer gets at least one wait state so hrdata can come from a flop
   always_ff @(posedge mclk) begin
      hresp <= 1'b0;
      if (rst) begin
         d_act <= 1'b0;
         d_wr <= 1'b0;
         d_addr <= 8'h0;
         hreadyout <= 1'b1;
         hrdata <= 32'h0;
      end else if (hsel && htrans[1] && hready) begin
         d_act <= 1'b1;
         d_wr <= hwrite;
         d_addr <= haddr[7:0];
         hreadyout <= 1'b0;
      end else if (done) begin
         d_act <= 1'b0;
         hreadyout <= 1'b1;
         hrdata <= d_wr ? 32'h0 : rd_mux;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         go_active_on_poll <= 1'b0;
         block_mode <= 1'b0;
         station <= 8'h0;
      end else if (wr_done && d_addr == `REG_CTRL) begin
         go_active_on_poll <= hwdata[`CTRL_GO];
         block_mode <= hwdata[`CTRL_BLOCK];
         station <= hwdata[`CTRL_ADDR];
      end
   end

   // ----------------------------------------
   // line decode
   // ----------------------------------------
   logic rx_bit, end_of_poll_pattern, first_poll, go_send, flag_seen;
   logic push, byte_done, addr_ok, store, frame_ovr, fifo_we, crc_err;
   logic [3:0] ones;
   logic [2:0] bitcnt;
   logic [7:0] rsh, nbyte;
   logic [13:0] bytecnt;
   logic [15:0] rcrc, rcrc_nx;
   loop_t loop;

   assign rx_bit = ring.down;
   assign end_of_poll_pattern = rx_bit && ones == `ONES_FLAG;
   assign flag_seen = !rx_bit && ones == `ONES_FLAG;
   assign push = rxs == RX_SYNC && !flag_seen && !end_of_poll_pattern
      && !(!rx_bit && ones == `ONES_STUFF);
   assign nbyte = {rx_bit, rsh[7:1]};
   assign byte_done = push && bitcnt == 3'h7;
   assign addr_ok = bytecnt != 14'h0 || nbyte == station
      || nbyte == `BCAST_ADDR;
   assign store = byte_done && addr_ok && !locked && (!rx_full || rd_done
      && d_addr == `REG_RXDATA);
   assign fifo_we = rxs == RX_SYNC && bytecnt != 14'h0
      && (flag_seen || end_of_poll_pattern);
   assign crc_err = rcrc != `CRC_GOOD || bitcnt != 3'h7
      || end_of_poll_pattern;
   assign first_poll = loop == LP_GATE && end_of_poll_pattern;
   assign go_send = loop == LP_RELAY && end_of_poll_pattern
      && go_active_on_poll;

   sdlc_crc16 rx_crc_u (.crc_in(rcrc), .data(nbyte), .crc_out(rcrc_nx));

   // a 0 seeds the count; reset at idle so power-up marks are no poll end
   always_ff @(posedge mclk) begin
      if (rst) begin
         ones <= `ONES_IDLE;
      end else if (!rx_bit) begin
         ones <= 4'h0;
      end else if (ones != `ONES_IDLE) begin
         ones <= ones + 4'h1;
      end
   end

   // abort and idle both throw the receiver back to hunt
   always_ff @(posedge mclk) begin
      if (rst) begin
         rxs <= RX_HUNT;
         bitcnt <= 3'h0;
         bytecnt <= 14'h0;
         rsh <= 8'h0;
         rcrc <= `CRC_INIT;
      end else if (end_of_poll_pattern) begin
         rxs <= RX_HUNT;
      end else if (flag_seen) begin
         rxs <= RX_SYNC;
         bitcnt <= 3'h0;
         bytecnt <= 14'h0;
         rcrc <= `CRC_INIT;
      end else if (push) begin
         bitcnt <= bitcnt + 3'h1;
         rsh <= nbyte;
         if (byte_done && !addr_ok) begin
            rxs <= RX_HUNT;
         end else if (byte_done) begin
            bytecnt <= bytecnt + 14'h1;
            rcrc <= rcrc_nx;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         rx_full <= 1'b0;
         rxbuf <= 8'h0;
         locked <= 1'b0;
         frame_ovr <= 1'b0;
         rx_req <= 1'b0;
      end else begin
         rx_req <= rx_full && !locked;
         if (store) begin
            rxbuf <= nbyte;
            rx_full <= 1'b1;
         end else if (rd_done && d_addr == `REG_RXDATA) begin
            rx_full <= 1'b0;
         end
         if (fifo_we && flag_seen) begin
            locked <= 1'b1;
         end else if (erst_cmd) begin
            locked <= 1'b0;
         end
         if (byte_done && addr_ok && !store) begin
            frame_ovr <= 1'b1;
         end else if (flag_seen) begin
            frame_ovr <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // frame status fifo
   // ----------------------------------------
   logic fifo_wok;
   assign fifo_pop = rd_done && d_addr == `REG_FSTAT && fcnt != 4'h0;
   assign fifo_wok = fifo_we && (fcnt != `FIFO_DEPTH || fifo_pop);

   always_ff @(posedge mclk) begin
      if (fifo_wok) begin
         fst_mem[fw] <= {crc_err, 1'b0, frame_ovr, bytecnt};
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         fw <= 4'h0;
         fr <= 4'h0;
         fcnt <= 4'h0;
         fifo_ovf <= 1'b0;
      end else begin
         if (fifo_wok) begin
            fw <= fw == `FIFO_LAST ? 4'h0 : fw + 4'h1;
         end
         if (fifo_pop) begin
            fr <= fr == `FIFO_LAST ? 4'h0 : fr + 4'h1;
         end
         fcnt <= fcnt + {3'h0, fifo_wok} - {3'h0, fifo_pop};
         if (fifo_we && !fifo_wok) begin
            fifo_ovf <= 1'b1;
         end else if (wr_done && d_addr == `REG_STATUS
            && hwdata[`STAT_OVF]) begin
            fifo_ovf <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // loop control and transmitter
   // ----------------------------------------
   tx_state_t txs;
   logic tx_q, tbit, pbit, stuff, tx_done, take, abort_req;
   logic [3:0] tcnt, tones;
   logic [15:0] tsh, tcrc, tcrc_nx;
   logic [7:0] flag_bits;

   assign flag_bits = `FLAG_BYTE;
   // only the wire-through path is not a flop: it must be gate delay
   assign ring.up = loop == LP_GATE ? rx_bit : tx_q;
   assign pbit = txs == TX_FCS ? tsh[15] : tsh[0];
   assign stuff = tones == `ONES_STUFF;
   assign take = tcnt[2:0] == 3'h7 && tx_full && !stuff && !abort_req
      && (txs == TX_FLAG || txs == TX_DATA);
   assign tx_done = (txs == TX_CLOSE && !stuff && tcnt == `LAST_BIT)
      || (txs == TX_MARK && tcnt == `LAST_BIT)
      || (txs == TX_FLAG && tcnt == `LAST_BIT && !tx_full
      && !go_active_on_poll);

   sdlc_crc16 tx_crc_u (.crc_in(txs == TX_FLAG ? `CRC_INIT : tcrc),
      .data(txbuf), .crc_out(tcrc_nx));

   always_comb begin
      case (txs)
         TX_FLAG: tbit = flag_bits[tcnt[2:0]];
         TX_CLOSE: tbit = stuff ? 1'b0 : flag_bits[tcnt[2:0]];
         TX_DATA, TX_FCS: tbit = stuff ? 1'b0 : pbit;
         default: tbit = 1'b1;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         loop <= LP_GATE;
         on_loop <= 1'b0;
         sending <= 1'b0;
         tx_q <= 1'b1;
      end else begin
         case (loop)
            LP_GATE: if (first_poll) begin
               loop <= LP_RELAY;
               on_loop <= 1'b1;
            end
            LP_RELAY: if (go_send) begin
               loop <= LP_SEND;
               sending <= 1'b1;
            end
            LP_SEND: if (tx_done) begin
               loop <= LP_RELAY;
               sending <= 1'b0;
            end
            default: loop <= LP_GATE;
         endcase
         if (loop == LP_SEND) begin
            tx_q <= tbit;
         end else if (go_send) begin
            tx_q <= 1'b0;
         end else begin
            tx_q <= rx_bit;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         ext_event <= 1'b0;
         brk <= 1'b0;
      end else begin
         if (first_poll || go_send) begin
            ext_event <= 1'b1;
            brk <= first_poll;
         end else if (wr_done && d_addr == `REG_STATUS
            && hwdata[`STAT_EXT]) begin
            ext_event <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         tx_full <= 1'b0;
         txbuf <= 8'h0;
      end else if (wr_done && d_addr == `REG_TXDATA && !tx_full) begin
         tx_full <= 1'b1;
         txbuf <= hwdata[7:0];
      end else if (take) begin
         tx_full <= 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst || loop != LP_SEND) begin
         txs <= TX_FLAG;
         tcnt <= 4'h0;
         tones <= 4'h0;
         tsh <= 16'h0;
         tcrc <= `CRC_INIT;
         abort_req <= 1'b0;
      end else begin
         if (abort_cmd) begin
            abort_req <= 1'b1;
         end
         if (take) begin
            txs <= TX_DATA;
            tcnt <= 4'h0;
            tsh <= {8'h0, txbuf};
            tcrc <= tcrc_nx;
            if (txs == TX_FLAG) begin
               tones <= 4'h0;
            end else begin
               tones <= pbit ? tones + 4'h1 : 4'h0;
            end
         end else if (txs == TX_FLAG || txs == TX_MARK) begin
            tcnt <= {1'b0, tcnt[2:0] + 3'h1};
         end else if (stuff) begin
            tones <= 4'h0;
         end else if (txs == TX_CLOSE) begin
            tcnt <= tcnt + 4'h1;
         end else begin
            tones <= pbit ? tones + 4'h1 : 4'h0;
            tsh <= txs == TX_FCS ? {tsh[14:0], 1'b0} : {1'b0, tsh[15:1]};
            tcnt <= tcnt + 4'h1;
            if (txs == TX_FCS && tcnt == `LAST_FCS_BIT) begin
               txs <= TX_CLOSE;
               tcnt <= 4'h0;
            end else if (txs == TX_DATA && tcnt == `LAST_BIT) begin
               tcnt <= 4'h0;
               if (abort_req || go_active_on_poll) begin
                  txs <= TX_MARK;
               end else begin
                  txs <= TX_FCS;
                  tsh <= tcrc;
               end
            end
         end
      end
   end
endmodule

// ==== hdl/sdlc_master.sv ====
`timescale 1ns/1ps
`include "sdlc_loop_consts.svh"
module sdlc_master
   import sdlc_loop_pkg::*;
(
   input wire logic mclk, // bit-rate clock
   input wire logic rst, // synchronous reset
   input wire logic [7:0] tx_data, // next octet to send
   input wire logic tx_valid, // tx_data holds an octet
   input wire logic tx_last, // tx_data is the last octet of the frame
   input wire logic poll, // hold the line marking for the secondaries
   output logic tx_ready, // pulse: octet was taken last edge
   output logic marking, // line is idling in marks
   output logic [7:0] rx_data, // received octet
   output logic rx_valid, // pulse: rx_data is new
   output logic rx_end, // pulse: closing flag seen
   output logic rx_crc_ok, // with rx_end: check sequence good
   sdlc_ring_if.master ring // ring line
);
   // ----------------------------------------
   // receiver
   // ----------------------------------------
   rx_state_t rxs;
   logic rx_bit, flag_seen, abort_seen, push;
   logic [3:0] ones;
   logic [2:0] bitcnt;
   logic [7:0] rsh, nbyte;
   logic [15:0] rcrc, rcrc_nx;
   logic in_frame;

   assign rx_bit = ring.up;
   assign flag_seen = !rx_bit && ones == `ONES_FLAG;
   assign abort_seen = rx_bit && ones == `ONES_FLAG;
   assign push = rxs == RX_SYNC && !flag_seen && !abort_seen
      && !(!rx_bit && ones == `ONES_STUFF);
   assign nbyte = {rx_bit, rsh[7:1]};

   sdlc_crc16 rx_crc_u (.crc_in(rcrc), .data(nbyte), .crc_out(rcrc_nx));

   always_ff @(posedge mclk) begin
      if (rst) begin
         ones <= `ONES_IDLE;
      end else if (!rx_bit) begin
         ones <= 4'h0;
      end else if (ones != `ONES_IDLE) begin
         ones <= ones + 4'h1;
      end
   end

   always_ff @(posedge mclk) begin
      rx_valid <= 1'b0;
      rx_end <= 1'b0;
      if (rst) begin
         rxs <= RX_HUNT;
         bitcnt <= 3'h0;
         rsh <= 8'h0;
         rcrc <= `CRC_INIT;
         in_frame <= 1'b0;
         rx_data <= 8'h0;
         rx_crc_ok <= 1'b0;
      end else if (abort_seen) begin
         rxs <= RX_HUNT;
         in_frame <= 1'b0;
      end else if (flag_seen) begin
         rxs <= RX_SYNC;
         rx_end <= in_frame;
         rx_crc_ok <= rcrc == `CRC_GOOD && bitcnt == 3'h7;
         bitcnt <= 3'h0;
         rcrc <= `CRC_INIT;
         in_frame <= 1'b0;
      end else if (push) begin
         bitcnt <= bitcnt + 3'h1;
         rsh <= nbyte;
         if (bitcnt == 3'h7) begin
            rcrc <= rcrc_nx;
            rx_data <= nbyte;
            rx_valid <= 1'b1;
            in_frame <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // transmitter
   // ----------------------------------------
   tx_state_t txs;
   logic tx_q, tbit, pbit, stuff, take, tlast, hold;
   logic [3:0] tcnt, tones;
   logic [15:0] tsh, tcrc, tcrc_nx;
   logic [7:0] flag_bits;

   assign ring.down = tx_q;
   assign flag_bits = `FLAG_BYTE;
   // marking lasts while asked and while a relayed frame is still arriving
   assign hold = poll || in_frame;
   assign pbit = txs == TX_FCS ? tsh[15] : tsh[0];
   assign stuff = tones == `ONES_STUFF;
   assign take = tcnt[2:0] == 3'h7 && tx_valid && !stuff
      && (txs == TX_FLAG || (txs == TX_DATA && !tlast));

   sdlc_crc16 tx_crc_u (.crc_in(txs == TX_FLAG ? `CRC_INIT : tcrc),
      .data(tx_data), .crc_out(tcrc_nx));

   always_comb begin
      case (txs)
         TX_FLAG: tbit = flag_bits[tcnt[2:0]];
         TX_CLOSE: tbit = stuff ? 1'b0 : flag_bits[tcnt[2:0]];
         TX_DATA, TX_FCS: tbit = stuff ? 1'b0 : pbit;
         default: tbit = 1'b1;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (rst) begin
         txs <= TX_FLAG;
         tcnt <= 4'h0;
         tones <= 4'h0;
         tsh <= 16'h0;
         tcrc <= `CRC_INIT;
         tlast <= 1'b0;
         tx_q <= 1'b1;
         tx_ready <= 1'b0;
         marking <= 1'b0;
      end else begin
         tx_q <= tbit;
         tx_ready <= take;
         marking <= txs == TX_MARK;
         if (take) begin
            txs <= TX_DATA;
            tcnt <= 4'h0;
            tsh <= {8'h0, tx_data};
            tcrc <= tcrc_nx;
            tlast <= tx_last;
            tones <= txs == TX_FLAG ? 4'h0 : (pbit ? tones + 4'h1 : 4'h0);
         end else if (txs == TX_FLAG) begin
            tcnt <= {1'b0, tcnt[2:0] + 3'h1};
            if (tcnt == `LAST_BIT && poll) begin
               txs <= TX_MARK;
               tcnt <= 4'h0;
            end
         end else if (txs == TX_MARK) begin
            if (tcnt != `LAST_BIT) begin
               tcnt <= tcnt + 4'h1;
            end else if (!hold) begin
               txs <= TX_FLAG;
               tcnt <= 4'h0;
            end
         end else if (stuff) begin
            tones <= 4'h0;
         end else if (txs == TX_CLOSE) begin
            tcnt <= tcnt + 4'h1;
            if (tcnt == `LAST_BIT) begin
               txs <= TX_FLAG;
               tcnt <= 4'h0;
            end
         end else begin
            tones <= pbit ? tones + 4'h1 : 4'h0;
            tsh <= txs == TX_FCS ? {tsh[14:0], 1'b0} : {1'b0, tsh[15:1]};
            tcnt <= tcnt + 4'h1;
            if (txs == TX_FCS && tcnt == `LAST_FCS_BIT) begin
               txs <= TX_CLOSE;
               tcnt <= 4'h0;
            end else if (txs == TX_DATA && tcnt == `LAST_BIT) begin
               tcnt <= 4'h0;
               txs <= tlast ? TX_FCS : TX_MARK;
               tsh <= tcrc;
            end
         end
      end
   end
endmodule

// ==== verification/sdlc_loop_framer_assertions.sv ====
`timescale 1ns/1ps
module sdlc_loop_framer_assertions (
   input wire logic mclk, // bit clock
   input wire logic rst, // sync reset
   input wire logic down, // master line out
   input wire logic up, // secondary line out
   input wire logic tx_ready, // master octet taken
   input wire logic rx_valid, // master octet in
   input wire logic rx_end, // master frame end
   input wire logic marking // master marking
);
   // ----
   // poll end tracking
   // ----
   // run saturates so reset-time ones never pass for a poll end
   logic [3:0] run;
   logic joined;
   logic eop_now;
   assign eop_now = down && run == 4'h6;
   always_ff @(posedge mclk) begin
      if (rst) run <= 4'hF;
      else if (!down) run <= 4'h0;
      else if (run != 4'hF) run <= run + 4'h1;
   end
   always_ff @(posedge mclk) begin
      if (rst) joined <= 1'b0;
      else if (eop_now) joined <= 1'b1;
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   a_reset_mark: assert property ($fell(rst) |-> down)
      else $error("line not marking out of reset");
   a_first_flag: assert property ($fell(rst)
      |=> !down ##1 down [*6] ##1 !down) else $error("no flag after reset");
   a_gate_wire: assert property (!joined |-> up == down)
      else $error("line not wired through");
   a_relay_delay: assert property (eop_now && !joined
      |=> (up == $past(down)) [*4]) else $error("relay delay wrong");
   a_octet_gap: assert property (tx_ready |=> !tx_ready [*7])
      else $error("octets taken too fast");
   a_rx_gap: assert property (rx_valid |=> !rx_valid [*7])
      else $error("octets received too fast");
   a_end_gap: assert property (rx_end |=> !rx_end [*7])
      else $error("frame ends too close");
   a_mark_hold: assert property ($rose(marking) |-> marking [*7])
      else $error("marking too short");
endmodule

// ==== verification/tb_sdlc_loop_framer.sv ====
`timescale 1ns/1ps
`include "sdlc_loop_consts.svh"
module tb_sdlc_loop_framer;
   typedef struct {logic [7:0] a, c, d; logic ok;} row_t;
   row_t rows[3] = '{'{8'h5A, 8'h03, 8'h7C, 1'b1},
      '{8'hFF, 8'h10, 8'h3F, 1'b1}, '{8'h33, 8'h11, 8'h42, 1'b0}};
   logic mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic hreadyout, hresp, rx_req, tx_ready, marking, rx_valid;
   logic rx_end, rx_crc_ok, prev;
   logic [7:0] tx_data = 8'h0, rx_data;
   logic tx_valid = 1'b0, tx_last = 1'b0, poll = 1'b0;
   logic [7:0] rxq[$], sq[$];
   int mismatches = 0, check_count = 0, cyc = 0, ends = 0, oks = 0;
   sdlc_ring_if ring();
   sdlc_secondary i_sdlc_secondary (.mclk(mclk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .rx_req(rx_req), .ring(ring));
   sdlc_master i_sdlc_master (.mclk(mclk), .rst(rst), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_last(tx_last), .poll(poll),
      .tx_ready(tx_ready), .marking(marking), .rx_data(rx_data),
      .rx_valid(rx_valid), .rx_end(rx_end), .rx_crc_ok(rx_crc_ok),
      .ring(ring));
   sdlc_loop_framer_assertions i_sdlc_loop_framer_assertions (.mclk(mclk),
      .rst(rst), .down(ring.down), .up(ring.up), .tx_ready(tx_ready),
      .rx_valid(rx_valid), .rx_end(rx_end), .marking(marking));
   always #12.5 mclk = ~mclk;
   // ----
   // helpers
   // ----
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // called just after an edge; holds each phase until hreadyout
   task automatic ahb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(hresp, 0);
   endtask
   task automatic send(input logic [7:0] b[3]);
      for (int i = 0; i < 3; i++) begin
         tx_data <= b[i];
         tx_valid <= 1'b1;
         tx_last <= (i == 2);
         do @(posedge mclk); while (tx_ready !== 1'b1);
      end
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
   endtask
   task automatic rdrx(input int n);
      for (int i = 0; i < n; i++) begin
         do @(posedge mclk); while (rx_req !== 1'b1);
         ahb(0, `REG_RXDATA, 0);
         sq.push_back(rd[7:0]);
      end
   endtask
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (rx_valid === 1'b1) rxq.push_back(rx_data);
      if (rx_end === 1'b1) ends++;
      if (rx_end === 1'b1 && rx_crc_ok === 1'b1) oks++;
      if (cyc > 20000) begin
         mismatches++;
         conclude();
      end
   end
   initial begin
      repeat (6) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      ahb(1, `REG_CTRL, 32'h5A00);
      foreach (rows[i]) begin
         sq.delete();
         ends = 0;
         oks = 0;
         fork
            send('{rows[i].a, rows[i].c, rows[i].d});
            rdrx(rows[i].ok ? 4 : 0);
         join
         while (ends == 0) @(posedge mclk);
         chk(oks, 1);
         ahb(0, `REG_FSTAT, 0);
         chk(rd & (rows[i].ok ? 32'hFFFFFFFF : 32'h80000000),
            rows[i].ok ? 32'h80000005 : 32'h0);
         chk(sq.size(), rows[i].ok ? 4 : 0);
         if (rows[i].ok) chk({sq[0], sq[1], sq[2]},
            {rows[i].a, rows[i].c, rows[i].d});
         ahb(0, `REG_RXDATA, 0);
         ahb(1, `REG_CTRL, 32'h5A08);
      end
      // a second reset mid-run, then join the loop
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
      @(posedge mclk);
      ahb(0, `REG_CTRL, 0);
      chk(rd, 0);
      ahb(0, `REG_STATUS, 0);
      chk(rd & 32'h3, 0);
      ahb(0, 8'h20, 0);
      chk(rd, 0);
      poll <= 1'b1;
      repeat (24) @(posedge mclk);
      ahb(0, `REG_STATUS, 0);
      chk(rd & 32'h1F, 32'h1D);
      chk(marking, 1);
      ahb(1, `REG_STATUS, 32'h4);
      ahb(0, `REG_STATUS, 0);
      chk(rd & 32'h4, 0);
      poll <= 1'b0;
      repeat (16) begin
         prev = ring.down;
         @(posedge mclk);
         chk(ring.up, prev);
      end
      // go active on the next poll end and send three octets
      ahb(1, `REG_CTRL, 32'h5A03);
      rxq.delete();
      ends = 0;
      oks = 0;
      poll <= 1'b1;
      repeat (24) @(posedge mclk);
      ahb(0, `REG_STATUS, 0);
      chk(rd & 32'hE, 32'h6);
      ahb(1, `REG_TXDATA, 32'h5A);
      ahb(1, `REG_TXDATA, 32'h03);
      ahb(1, `REG_TXDATA, 32'h7C);
      ahb(1, `REG_CTRL, 32'h5A02);
      while (ends == 0) @(posedge mclk);
      chk(oks, 1);
      chk({rxq[0], rxq[1], rxq[2]}, 24'h5A037C);
      repeat (16) @(posedge mclk);
      ahb(0, `REG_STATUS, 0);
      chk(rd & 32'h3, 32'h1);
      poll <= 1'b0;
      conclude();
   end
endmodule
